/* bench/meter_reader.sv */
// Far-side reader model collecting the character-serial BCD digits
`timescale 1ns/1ns
module meter_reader
    import meter_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire serial_out_t serial_port,
    input  wire logic        output_updating,
    output bcd_word_t        word_seen,
    output logic             order_err,
    output logic             window_err
);
    logic [1:0]  step_q;
    serial_out_t last_q;
    logic        upd_q;
    logic [3:0]  strb;
    logic [3:0]  want;

    // Strobes as units, tens, hundreds, thousands; walk order differs
    assign strb = serial_port[3:0];
    always_comb begin
        case (step_q)
            2'h0:    want = 4'h8;
            2'h1:    want = 4'h2;
            2'h2:    want = 4'h4;
            default: want = 4'h1;
        endcase
    end

    // Thousands strobe stands between frames, so act on strobe changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_q     <= 2'h0;
            last_q     <= '0;
            upd_q      <= 1'b0;
            order_err  <= 1'b0;
            window_err <= 1'b0;
            word_seen  <= '0;
        end else begin
            last_q <= serial_port;
            upd_q  <= output_updating;
            if (serial_port !== last_q && !output_updating && !upd_q) begin
                window_err <= 1'b1;
            end
            if (strb != 4'h0 && strb != last_q[3:0]) begin
                if (strb !== want) begin
                    order_err <= 1'b1;
                end
                case (step_q)
                    2'h0:    word_seen.units <= serial_port.bcd;
                    2'h1:    word_seen.hund  <= serial_port.bcd;
                    2'h2:    word_seen.tens  <= serial_port.bcd;
                    default: word_seen.thou  <= serial_port.bcd;
                endcase
                step_q <= step_q + 2'h1;
            end
        end
    end
endmodule : meter_reader

/* bench/panel_meter_conversion_output_control_tb.sv */
// Bench for the panel meter conversion and output control block
`timescale 1ns/1ns
module panel_meter_conversion_output_control_tb
    import meter_pkg::*;
;
    localparam int unsigned PER = 200;
    localparam int unsigned UPD = 20;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        display_off_n = 1'b1;
    logic        convert_freeze_n = 1'b1;
    logic        output_freeze_n = 1'b1;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, conversion_busy_n, output_updating;
    logic        data_valid, irq, order_err, window_err, upd_d, lit_p;
    serial_out_t serial_port;
    par_out_t    parallel_port;
    display_t    display;
    bcd_word_t   word_seen;
    int          fails = 0, compares = 0, cyc = 0, rises = 0, n;
    int          period = 0, last_r = 0, uc = 0, width = 0;

    always #25 hclk = ~hclk;

    panel_meter_conversion_output_control #(.CONV_PERIOD(PER),
        .UPDATE_LEN(UPD), .FLASH_LEN(10)) u_panel_meter_conversion_output_control (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .display_off_n(display_off_n),
        .convert_freeze_n(convert_freeze_n),
        .output_freeze_n(output_freeze_n), .serial_port(serial_port),
        .conversion_busy_n(conversion_busy_n), .parallel_port(parallel_port),
        .output_updating(output_updating), .data_valid(data_valid),
        .display(display), .irq(irq));

    meter_reader u_meter_reader (.hclk(hclk), .hresetn(hresetn),
        .serial_port(serial_port), .output_updating(output_updating),
        .word_seen(word_seen), .order_err(order_err),
        .window_err(window_err));

    // Window monitor: cadence from rise to rise, width of the window
    always @(posedge hclk) begin
        cyc   <= cyc + 1;
        upd_d <= output_updating;
        if (output_updating === 1'b1 && upd_d !== 1'b1) begin
            rises  <= rises + 1;
            period <= cyc - last_r;
            last_r <= cyc;
        end
        if (output_updating === 1'b1) begin
            uc <= uc + 1;
        end else if (upd_d === 1'b1) begin
            width <= uc;
            uc    <= 0;
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One single word transfer; slave wait states are honoured
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(what, exp, rd);
        check("hresp", 32'h0, 32'(hresp));
    endtask : rdchk

    // Bounded wait for the end of the next update window
    task automatic wait_conv();
        n = 0;
        while (output_updating !== 1'b1 && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        check("busy", 32'h0, 32'(conversion_busy_n));
        while (output_updating !== 1'b0 && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        check("conversion end", 32'h0, 32'(n >= 1000));
        repeat (2) @(posedge hclk);
    endtask : wait_conv

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Tests need some fifteen conversion periods; limit is well beyond
    initial begin
        repeat (60 * PER) @(posedge hclk);
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("ctrl reset", OFS_CTRL, 32'h7);
        rdchk("unmapped", 8'h20, 32'h0);
        check("valid at reset", 32'h0, 32'(data_valid));
        $display("test reset done");
        ahb(1'b1, OFS_SAMPLE, 32'h0000_04D2);
        wait_conv();
        wait_conv();
        check("period", PER, 32'(period));
        check("window", UPD, 32'(width));
        check("parallel", 32'h1234, 32'(parallel_port.digits));
        check("display", 32'h1234, 32'(display.digits));
        check("positive", 32'h1, 32'(parallel_port.positive));
        check("valid", 32'h1, 32'(data_valid));
        rdchk("status", OFS_STATUS, 32'h1);
        check("serial", 32'h1234, 32'(word_seen));
        check("order", 32'h0, 32'(order_err));
        rdchk("result", OFS_RESULT, 32'h1234);
        $display("test cadence done");
        for (int i = 0; i < 3; i++) begin
            ahb(1'b1, OFS_CTRL, 32'(3'h7 ^ (3'h1 << i)));
            repeat (2) @(posedge hclk);
            check("point", 32'(3'h1 << i), 32'(display.points));
        end
        // Blank with every point selected: two points must stay lit
        ahb(1'b1, OFS_CTRL, 32'h0);
        display_off_n <= 1'b0;
        repeat (4) @(posedge hclk);
        check("blank lit", 32'h0, 32'(display.lit));
        check("blank pts", 32'h6, 32'(display.points));
        check("blank bcd", 32'h1234, 32'(parallel_port.digits));
        display_off_n <= 1'b1;
        repeat (4) @(posedge hclk);
        check("unblank", 32'h1, 32'(display.lit));
        $display("test blanking done");
        output_freeze_n <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb(1'b1, OFS_SAMPLE, 32'h0000_0237);
        wait_conv();
        wait_conv();
        check("held", 32'h1234, 32'(parallel_port.digits));
        check("shown", 32'h0567, 32'(display.digits));
        repeat (50) @(posedge hclk);
        output_freeze_n <= 1'b1;
        repeat (4) @(posedge hclk);
        check("no early", 32'h1234, 32'(parallel_port.digits));
        wait_conv();
        check("refresh", 32'h0567, 32'(parallel_port.digits));
        $display("test output hold done");
        convert_freeze_n <= 1'b0;
        repeat (4) @(posedge hclk);
        // A conversion already under way still completes
        wait_conv();
        n = rises;
        ahb(1'b1, OFS_SAMPLE, 32'h0000_0100);
        repeat (3 * PER) @(posedge hclk);
        check("frozen", 32'(n), 32'(rises));
        check("kept", 32'h0567, 32'(display.digits));
        convert_freeze_n <= 1'b1;
        repeat (4) @(posedge hclk);
        check("invalid", 32'h0, 32'(data_valid));
        wait_conv();
        wait_conv();
        check("valid again", 32'h1, 32'(data_valid));
        check("new", 32'h0256, 32'(display.digits));
        $display("test converter hold done");
        ahb(1'b1, OFS_MASK, 32'h1);
        ahb(1'b1, OFS_IRQ, 32'h3);
        wait_conv();
        check("irq set", 32'h1, 32'(irq));
        rdchk("irq done", OFS_IRQ, 32'h1);
        ahb(1'b1, OFS_IRQ, 32'h1);
        repeat (2) @(posedge hclk);
        check("irq clear", 32'h0, 32'(irq));
        ahb(1'b1, OFS_MASK, 32'h0);
        wait_conv();
        check("irq masked", 32'h0, 32'(irq));
        $display("test interrupt done");
        // Negative overload: flash, sign kept, three digits shown
        ahb(1'b1, OFS_SAMPLE, 32'h0001_08FC);
        wait_conv();
        check("ovl", 32'h0, 32'(parallel_port.overload_n));
        check("sign", 32'h1, 32'(display.negative_sign));
        check("pol", 32'h0, 32'(parallel_port.positive));
        check("ovl digits", 32'h0300, 32'(display.digits));
        rdchk("irq ovl", OFS_IRQ, 32'h3);
        n = 0;
        repeat (40) begin
            lit_p = display.lit;
            @(posedge hclk);
            n = n + 32'(display.lit !== lit_p);
        end
        check("flash", 32'h1, 32'(n >= 2));
        check("serial window", 32'h0, 32'(window_err));
        $display("test overload done");
        give_verdict();
    end
endmodule : panel_meter_conversion_output_control_tb

/* core/panel_meter_conversion_output_control.sv */
// Conversion cadence, display and BCD output control of the panel meter
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module panel_meter_conversion_output_control
    import meter_pkg::*;
#(
    parameter int unsigned CONV_PERIOD = CONV_CYCLES,
    parameter int unsigned UPDATE_LEN  = UPDATE_CYCLES,
    parameter int unsigned FLASH_LEN   = FLASH_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        display_off_n,
    input  wire logic        convert_freeze_n,
    input  wire logic        output_freeze_n,
    output serial_out_t      serial_port,
    output logic             conversion_busy_n,
    output par_out_t         parallel_port,
    output logic             output_updating,
    output logic             data_valid,
    output display_t         display,
    output logic             irq
);
    // Whole state of the block in one record
    typedef struct packed {
        logic [2:0]  sync_a;
        logic [2:0]  sync_b;
        logic [31:0] conv_cnt;
        logic [31:0] upd_cnt;
        logic [31:0] flash_cnt;
        logic        flash_on;
        conv_state_t state;
        logic [1:0]  settle;
        logic        was_frozen;
        logic [15:0] count;
        logic        negative;
        bcd_word_t   result;
        logic        res_neg;
        logic        res_ovl;
        bcd_word_t   shift;
        logic [1:0]  walk;
        serial_out_t ser;
        par_out_t    par;
        logic        par_pending;
        logic [2:0]  point_ctrl;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic        dph_write;
        logic [7:0]  dph_addr;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Binary count to BCD, used for both the result and the overload clamp
    function automatic bcd_word_t to_bcd(input logic [15:0] v);
        bcd_word_t b;
        b.thou  = 4'((v / 16'd1000) % 16'd10);
        b.hund  = 4'((v / 16'd100) % 16'd10);
        b.tens  = 4'((v / 16'd10) % 16'd10);
        b.units = 4'(v % 16'd10);
        return b;
    endfunction : to_bcd

    // Strobe pattern for a position in the serial walk
    function automatic serial_out_t strobe_for(input logic [1:0] w,
                                               input bcd_word_t r);
        serial_out_t o;
        o = '0;
        case (digit_sel_t'(w))
            DIG_UNITS: begin
                o.units_digit_strobe = 1'b1;
                o.bcd = r.units;
            end
            DIG_HUND: begin
                o.hundreds_digit_strobe = 1'b1;
                o.bcd = r.hund;
            end
            DIG_TENS: begin
                o.tens_digit_strobe = 1'b1;
                o.bcd = r.tens;
            end
            default: begin
                o.thousands_digit_strobe = 1'b1;
                o.bcd = r.thou;
            end
        endcase
        return o;
    endfunction : strobe_for

    logic blank_n;
    logic freeze_n;
    logic hold_n;
    logic take;
    logic [15:0] clamp;
    logic [IRQ_W-1:0] ev;

    // Second synchroniser stage is the only one the logic reads
    assign blank_n  = s_q.sync_b[0];
    assign freeze_n = s_q.sync_b[1];
    assign hold_n   = s_q.sync_b[2];
    assign take     = hsel & hready & htrans[1];

    always_comb begin
        s_d = s_q;
        clamp = s_q.count;
        ev = '0;
        // Two flip-flops per asynchronous control pin
        s_d.sync_a = {output_freeze_n, convert_freeze_n, display_off_n};
        s_d.sync_b = s_q.sync_a;

        // Flash divider runs continuously so overload blinks steadily
        if (s_q.flash_cnt >= FLASH_LEN - 1) begin
            s_d.flash_cnt = '0;
            s_d.flash_on  = ~s_q.flash_on;
        end else begin
            s_d.flash_cnt = s_q.flash_cnt + 32'd1;
        end

        // Conversion cadence; output-freeze gates only the parallel latch here
        case (s_q.state)
            ST_IDLE: begin
                if (freeze_n) begin
                    s_d.state    = ST_CONVERT;
                    s_d.conv_cnt = '0;
                end
            end
            ST_CONVERT: begin
                if (s_q.conv_cnt >= CONV_PERIOD - UPDATE_LEN - 1) begin
                    if (s_q.count > 16'(FULL_SCALE)) begin
                        clamp = s_q.count % 16'd1000;
                    end
                    s_d.result   = to_bcd(clamp);
                    s_d.res_neg  = s_q.negative;
                    s_d.res_ovl  = s_q.count > 16'(FULL_SCALE);
                    s_d.walk     = '0;
                    s_d.upd_cnt  = '0;
                    s_d.state    = ST_UPDATE;
                    ev[IRQ_DONE] = 1'b1;
                    if (s_q.count > 16'(FULL_SCALE)) begin
                        ev[IRQ_OVLD] = 1'b1;
                    end
                    if (s_q.settle != '0) begin
                        s_d.settle = s_q.settle - 2'd1;
                    end
                end else begin
                    s_d.conv_cnt = s_q.conv_cnt + 32'd1;
                end
            end
            default: begin
                // Update window: serial data and parallel latch change here
                s_d.ser = strobe_for(s_q.walk, s_q.result);
                if (s_q.walk != 2'd3) begin
                    s_d.walk = s_q.walk + 2'd1;
                end
                // Each digit on the serial lines is caught by its strobe
                if (s_q.ser.units_digit_strobe) begin
                    s_d.shift.units = s_q.ser.bcd;
                end
                if (s_q.ser.hundreds_digit_strobe) begin
                    s_d.shift.hund = s_q.ser.bcd;
                end
                if (s_q.ser.tens_digit_strobe) begin
                    s_d.shift.tens = s_q.ser.bcd;
                end
                if (s_q.ser.thousands_digit_strobe) begin
                    s_d.shift.thou = s_q.ser.bcd;
                end
                if (s_q.upd_cnt >= UPDATE_LEN - 1) begin
                    if (hold_n) begin
                        s_d.par.digits = s_q.shift;
                        s_d.par.positive   = ~s_q.res_neg;
                        s_d.par.overload_n = ~s_q.res_ovl;
                    end
                    // A held refresh stays owed; release waits for next end
                    s_d.par_pending = !hold_n;
                    s_d.state    = freeze_n ? ST_CONVERT : ST_IDLE;
                    s_d.conv_cnt = '0;
                end else begin
                    s_d.upd_cnt = s_q.upd_cnt + 32'd1;
                end
            end
        endcase
        if (!freeze_n) begin
            s_d.was_frozen = 1'b1;
        end else if (s_q.was_frozen) begin
            s_d.was_frozen = 1'b0;
            s_d.settle     = 2'(SETTLE_CONVS);
        end
        // Bus data phase: write side effects
        if (s_q.dph_write) begin
            if (s_q.dph_addr == OFS_CTRL) begin
                s_d.point_ctrl = hwdata[CTRL_POINT_LSB +: 3];
            end else if (s_q.dph_addr == OFS_SAMPLE) begin
                s_d.count    = hwdata[15:0];
                s_d.negative = hwdata[SAMPLE_NEG_BIT];
            end else if (s_q.dph_addr == OFS_IRQ) begin
                s_d.irq_stat = s_q.irq_stat & ~hwdata[IRQ_W-1:0];
            end else if (s_q.dph_addr == OFS_MASK) begin
                s_d.irq_mask = hwdata[IRQ_W-1:0];
            end
        end
        // Events land after any clear, so a set in the same cycle wins
        s_d.irq_stat = s_d.irq_stat | ev;

        // Address phase capture; reads answer in the next cycle
        s_d.dph_write = take & hwrite;
        s_d.dph_addr  = haddr[7:0];
        s_d.rdata     = '0;
        if (take && !hwrite) begin
            if (haddr[7:0] == OFS_CTRL) begin
                s_d.rdata = 32'(s_q.point_ctrl);
            end else if (haddr[7:0] == OFS_SAMPLE) begin
                s_d.rdata = {15'h0000, s_q.negative, s_q.count};
            end else if (haddr[7:0] == OFS_STATUS) begin
                s_d.rdata = {28'h0000000, s_q.res_ovl, s_q.res_neg,
                             (s_q.state == ST_UPDATE), (s_q.settle == '0)};
            end else if (haddr[7:0] == OFS_IRQ) begin
                s_d.rdata = 32'(s_q.irq_stat);
            end else if (haddr[7:0] == OFS_MASK) begin
                s_d.rdata = 32'(s_q.irq_mask);
            end else if (haddr[7:0] == OFS_RESULT) begin
                s_d.rdata = {16'h0000, s_q.result};
            end
        end
    end

    // Block state; reset leaves every control pin seen as released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.sync_a <= 3'h7;
            s_q.sync_b <= 3'h7;
            s_q.point_ctrl <= CTRL_RESET;
            s_q.par.overload_n <= 1'b1;
            s_q.settle <= 2'(SETTLE_CONVS);
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Display: blanking only gates the lamps, never the data
    always_comb begin
        display.digits        = s_q.result;
        display.negative_sign = s_q.res_neg;
        display.points        = ~s_q.point_ctrl;
        display.lit = blank_n & ~(s_q.res_ovl & s_q.flash_on);
        if (!blank_n) begin
            // Tens and hundreds points stay lit while blanked
            display.points = ~s_q.point_ctrl & 3'h6;
        end
    end

    // Bus and pin outputs
    assign hrdata            = s_q.rdata;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign serial_port       = s_q.ser;
    assign conversion_busy_n = (s_q.state != ST_UPDATE);
    assign parallel_port     = s_q.par;
    assign output_updating   = (s_q.state == ST_UPDATE);
    assign data_valid        = (s_q.settle == '0);
    assign irq               = |(s_q.irq_stat & s_q.irq_mask);

    a_updating_len: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(output_updating) |-> output_updating [*2])
        else $error("update window shorter than expected");
    a_freeze_stops: assert property (@(posedge hclk) disable iff (!hresetn)
        (!freeze_n && s_q.state == ST_IDLE) |=> s_q.state == ST_IDLE)
        else $error("conversion started while frozen");
    a_hold_par: assert property (@(posedge hclk) disable iff (!hresetn)
        !hold_n |=> $stable(parallel_port))
        else $error("parallel outputs moved under hold");
    a_blank_points: assert property (@(posedge hclk) disable iff (!hresetn)
        !blank_n |-> (display.points[0] == 1'b0 && !display.lit))
        else $error("blanking left segments on");
    a_one_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        $onehot0({serial_port.units_digit_strobe,
                  serial_port.tens_digit_strobe,
                  serial_port.hundreds_digit_strobe,
                  serial_port.thousands_digit_strobe}))
        else $error("more than one digit strobe high");
    a_serial_order: assert property (@(posedge hclk) disable iff (!hresetn)
        serial_port.units_digit_strobe && output_updating
        |=> serial_port.hundreds_digit_strobe)
        else $error("hundreds did not follow units");
    a_serial_window: assert property (@(posedge hclk) disable iff (!hresetn)
        !output_updating && !$past(output_updating)
        |-> $stable(serial_port))
        else $error("serial data changed outside update");
    a_blank_data: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(blank_n) && !output_updating |-> $stable(display.digits))
        else $error("blanking disturbed data");
    a_settle_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(freeze_n) |=> !data_valid)
        else $error("data valid right after freeze release");

    // Later checks share the bus clock and rest while in reset
    default clocking chk_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_lit_unblank: assert property (
        blank_n && !s_q.res_ovl |-> display.lit)
        else $error("display dark while not blanked");
    a_par_digits: assert property (
        hold_n && output_updating && s_q.upd_cnt == UPDATE_LEN - 1
        |=> parallel_port.digits == s_q.result)
        else $error("parallel word differs from result");
    a_owed_refresh: assert property (
        $fell(output_updating) |-> s_q.par_pending == !$past(hold_n))
        else $error("withheld refresh not tracked");
    a_hund_tens: assert property (
        serial_port.hundreds_digit_strobe |=> serial_port.tens_digit_strobe)
        else $error("tens did not follow hundreds");
    a_tens_thou: assert property (
        serial_port.tens_digit_strobe |=> serial_port.thousands_digit_strobe)
        else $error("thousands did not follow tens");
    a_frozen_shown: assert property (
        !freeze_n && s_q.state == ST_IDLE |-> $stable(display.digits))
        else $error("display changed while frozen");
    a_flash_lamps: assert property (
        blank_n && $stable(blank_n) && $stable(s_q.res_ovl) && s_q.res_ovl
        && $changed(s_q.flash_on) |-> $changed(display.lit))
        else $error("overload flash missing");
    a_ovl_flag: assert property (
        $fell(output_updating) && $past(hold_n)
        |-> parallel_port.overload_n == !s_q.res_ovl)
        else $error("overload output wrong after refresh");
endmodule : panel_meter_conversion_output_control

/* shared/meter_pkg.sv */
// Constants, register map and carrier types for the panel meter control
// Notes on behaviour
// - Free-running conversions five per second, outputs update
// - Blank input low blanks all except two points
// - Blanking leaves BCD data alone, display recovers at once
// - Convert-freeze low stops conversions, keeps last result
// - After freeze release, data invalid for conversions
// - Each point select low lights its point
// - Output-freeze low holds parallel outputs, else refresh
// - Output-freeze never stops conversions or display
// - Parallel word built by shift register from serial
// - Four shared BCD lines, one digit at once
// - Overload flashes display, polarity stays shown
// - Three digits, overrange digit, sign, automatic polarity
// - Serial order units, hundreds, tens, thousands with strobe
// - Serial data changes only within update window
// - Parallel invalid two ms window, updating flag high
// - Freeze release refreshes at next conversion end
package meter_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned CONV_PER_SEC   = 5;
    localparam int unsigned CONV_CYCLES    = CLK_HZ / CONV_PER_SEC;
    localparam int unsigned UPDATE_MS      = 2;
    localparam int unsigned UPDATE_CYCLES  = CLK_HZ / 1000 * UPDATE_MS;
    localparam int unsigned FLASH_HZ       = 2;
    localparam int unsigned FLASH_CYCLES   = CLK_HZ / (2 * FLASH_HZ);
    localparam int unsigned SETTLE_CONVS   = 2;
    localparam int unsigned FULL_SCALE     = 1999;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SAMPLE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ    = 8'h0C;
    localparam logic [7:0] OFS_MASK   = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;

    // Interrupt status bit positions
    localparam int unsigned IRQ_DONE  = 0;
    localparam int unsigned IRQ_OVLD  = 1;
    localparam int unsigned IRQ_W     = 2;

    // Ctrl register fields
    localparam int unsigned CTRL_POINT_LSB = 0;
    localparam logic [2:0]  CTRL_RESET     = 3'h7;

    // Sample register: measured count and sign from the converter
    localparam int unsigned SAMPLE_NEG_BIT = 16;
    localparam logic [15:0] DIGIT_MASK     = 16'h000F;

    // Serial walk, order units, hundreds, tens, thousands
    typedef enum logic [1:0] {
        DIG_UNITS, DIG_HUND, DIG_TENS, DIG_THOU
    } digit_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_CONVERT, ST_UPDATE
    } conv_state_t;

    typedef struct packed {
        logic [3:0] thou;
        logic [3:0] hund;
        logic [3:0] tens;
        logic [3:0] units;
    } bcd_word_t;

    typedef struct packed {
        logic [3:0] bcd;
        logic       units_digit_strobe;
        logic       tens_digit_strobe;
        logic       hundreds_digit_strobe;
        logic       thousands_digit_strobe;
    } serial_out_t;

    typedef struct packed {
        bcd_word_t  digits;
        logic       positive;
        logic       overload_n;
    } par_out_t;

    typedef struct packed {
        bcd_word_t  digits;
        logic       negative_sign;
        logic [2:0] points;
        logic       lit;
    } display_t;
endpackage : meter_pkg
